// File: design/dbm_top.sv
// Debug bus comparator block with Wishbone register access
//
// Local design decisions: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
module dbm_top #(
    parameter int CPU_AW = dbm_pkg::CPU_AW
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [dbm_pkg::WB_AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [dbm_pkg::WB_DW-1:0] wb_dat_i,
    output logic [dbm_pkg::WB_DW-1:0] wb_dat_o,
    output logic wb_ack_o,
    // Watched processor bus
    input wire logic cpu_valid_i,
    input wire logic [CPU_AW-1:0] cpu_addr_i,
    input wire logic [dbm_pkg::CPU_DW-1:0] cpu_data_i,
    input wire logic cpu_read_i,
    input wire logic cpu_word_i,
    input wire logic cpu_opfetch_i,
    // Results
    output logic [dbm_pkg::NUM_CMP-1:0] match_o,
    output logic trace_in_range_o,
    output logic irq_o
);
    localparam int N = dbm_pkg::NUM_CMP;
    localparam int DW = dbm_pkg::CPU_DW;
    localparam int IDX_C = 2;
    localparam int IDX_D = 3;

    // ============================================================
    // Helpers
    function automatic logic [31:0] wb_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [7:0] cmp_reg_addr(input int k, input logic [7:0] ofs);
        return 8'((k * 32'(dbm_pkg::CMP_STRIDE)) + 32'(ofs));
    endfunction

    // ============================================================
    // Register state
    logic [CPU_AW-1:0] cmp_addr_reg [N];
    logic [CPU_AW-1:0] cmp_addr_next [N];
    logic [DW-1:0] cmp_data_reg [N];
    logic [DW-1:0] cmp_data_next [N];
    logic [DW-1:0] cmp_mask_reg [N];
    logic [DW-1:0] cmp_mask_next [N];
    logic [dbm_pkg::CTRL_W-1:0] cmp_ctrl_reg [N];
    logic [dbm_pkg::CTRL_W-1:0] cmp_ctrl_next [N];
    logic [N-1:0] rearm;
    logic [1:0] trace_range_select_reg;
    logic [1:0] trace_range_select_next;
    logic [N-1:0] irq_status_reg;
    logic [N-1:0] irq_status_next;
    logic [N-1:0] irq_mask_reg;
    logic [N-1:0] irq_mask_next;
    logic wb_ack_reg;
    logic wb_ack_next;
    logic [31:0] wb_dat_reg;
    logic [31:0] wb_dat_next;
    logic [N-1:0] match_reg;
    logic [N-1:0] match_next;
    logic range_reg;
    logic range_next;
    logic irq_reg;
    logic irq_next;

    logic [N-1:0] hit;
    logic wb_req;
    logic wb_wr;
    logic wb_rd;
    logic [7:0] byte_adr;
    logic status_rd;

    // ============================================================
    // Comparators; A and C are built without size control
    for (genvar k = 0; k < N; k++) begin : g_cmp
        dbm_cmp #(
            .AW(CPU_AW),
            .DW(DW),
            .HAS_SIZE((k % 2) == 1)
        ) u_cmp (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .cmp_addr_i(cmp_addr_reg[k]),
            .cmp_data_i(cmp_data_reg[k]),
            .cmp_mask_i(cmp_mask_reg[k]),
            .cmp_ctrl_i(cmp_ctrl_reg[k]),
            .rearm_i(rearm[k]),
            .bus_valid_i(cpu_valid_i),
            .bus_addr_i(cpu_addr_i),
            .bus_data_i(cpu_data_i),
            .bus_read_i(cpu_read_i),
            .bus_word_i(cpu_word_i),
            .bus_opfetch_i(cpu_opfetch_i),
            .hit_o(hit[k])
        );
    end

    // ============================================================
    // Wishbone register access
    always_comb begin
        wb_req = wb_cyc_i && wb_stb_i && !wb_ack_reg;
        wb_wr = wb_req && wb_we_i;
        wb_rd = wb_req && !wb_we_i;
        byte_adr = {wb_adr_i[dbm_pkg::WB_AW-1:2], 2'b00};
        wb_ack_next = wb_req;
        wb_dat_next = 32'h0000_0000;
        status_rd = 1'b0;
        rearm = '0;
        trace_range_select_next = trace_range_select_reg;
        irq_mask_next = irq_mask_reg;
        for (int k = 0; k < N; k++) begin
            cmp_addr_next[k] = cmp_addr_reg[k];
            cmp_data_next[k] = cmp_data_reg[k];
            cmp_mask_next[k] = cmp_mask_reg[k];
            cmp_ctrl_next[k] = cmp_ctrl_reg[k];
            if (byte_adr == cmp_reg_addr(k, dbm_pkg::CMP_ADDR_OFS)) begin
                wb_dat_next = 32'(cmp_addr_reg[k]);
                if (wb_wr) begin
                    cmp_addr_next[k] = CPU_AW'(wb_merge(32'(cmp_addr_reg[k]), wb_dat_i,
                                                        wb_sel_i));
                end
            end
            // Software follows the byte-lane conventions
            if (byte_adr == cmp_reg_addr(k, dbm_pkg::CMP_DATA_OFS)) begin
                wb_dat_next = 32'(cmp_data_reg[k]);
                if (wb_wr) begin
                    cmp_data_next[k] = DW'(wb_merge(32'(cmp_data_reg[k]), wb_dat_i,
                                                    wb_sel_i));
                end
            end
            if (byte_adr == cmp_reg_addr(k, dbm_pkg::CMP_MASK_OFS)) begin
                wb_dat_next = 32'(cmp_mask_reg[k]);
                if (wb_wr) begin
                    cmp_mask_next[k] = DW'(wb_merge(32'(cmp_mask_reg[k]), wb_dat_i,
                                                    wb_sel_i));
                end
            end
            if (byte_adr == cmp_reg_addr(k, dbm_pkg::CMP_CTRL_OFS)) begin
                wb_dat_next = 32'(cmp_ctrl_reg[k]);
                if (wb_wr) begin
                    // Rewriting control starts a fresh full check
                    rearm[k] = 1'b1;
                    cmp_ctrl_next[k] = dbm_pkg::CTRL_W'(wb_merge(32'(cmp_ctrl_reg[k]),
                                                                 wb_dat_i, wb_sel_i));
                end
            end
        end
        if (byte_adr == dbm_pkg::TRACE_CTRL_ADDR) begin
            wb_dat_next = 32'(trace_range_select_reg);
            if (wb_wr && wb_sel_i[0]) begin
                trace_range_select_next = wb_dat_i[1:0];
            end
        end
        if (byte_adr == dbm_pkg::IRQ_STATUS_ADDR) begin
            wb_dat_next = 32'(irq_status_reg);
            status_rd = wb_rd;
        end
        if (byte_adr == dbm_pkg::IRQ_MASK_ADDR) begin
            wb_dat_next = 32'(irq_mask_reg);
            if (wb_wr && wb_sel_i[0]) begin
                irq_mask_next = wb_dat_i[N-1:0];
            end
        end
        if (!wb_rd) begin
            wb_dat_next = 32'h0000_0000;
        end
    end

    // ============================================================
    // Match routing and trace range
    logic use_c;
    logic use_d;
    logic above_c;
    logic below_d;
    logic in_range;

    always_comb begin
        use_c = trace_range_select_reg[0];
        use_d = trace_range_select_reg[1];
        above_c = cpu_addr_i >= cmp_addr_reg[IDX_C];
        below_d = cpu_addr_i <= cmp_addr_reg[IDX_D];
        in_range = (!use_c || above_c) && (!use_d || below_d);
        // With range off there is no trace window to report
        range_next = cpu_valid_i && (use_c || use_d) && in_range;
        match_next = hit;
        // A bound comparator is busy defining the range
        if (use_c) begin
            match_next[IDX_C] = 1'b0;
        end
        if (use_d) begin
            match_next[IDX_D] = 1'b0;
        end
        // In range modes slot D, or slot C when only C bounds, reports in-range accesses
        if (use_d) begin
            match_next[IDX_D] = cpu_valid_i && in_range;
        end else if (use_c) begin
            match_next[IDX_C] = cpu_valid_i && in_range;
        end
        // New events win over the read that clears them
        irq_status_next = (status_rd ? '0 : irq_status_reg) | match_next;
        irq_next = |(irq_status_next & irq_mask_next);
    end

    // ============================================================
    // Registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int k = 0; k < N; k++) begin
                cmp_addr_reg[k] <= '0;
                cmp_data_reg[k] <= '0;
                cmp_mask_reg[k] <= dbm_pkg::MASK_RESET;
                cmp_ctrl_reg[k] <= dbm_pkg::CTRL_RESET;
            end
            trace_range_select_reg <= dbm_pkg::RANGE_RESET;
            irq_status_reg <= '0;
            irq_mask_reg <= '0;
            wb_ack_reg <= 1'b0;
            wb_dat_reg <= 32'h0000_0000;
            match_reg <= '0;
            range_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            for (int k = 0; k < N; k++) begin
                cmp_addr_reg[k] <= cmp_addr_next[k];
                cmp_data_reg[k] <= cmp_data_next[k];
                cmp_mask_reg[k] <= cmp_mask_next[k];
                cmp_ctrl_reg[k] <= cmp_ctrl_next[k];
            end
            trace_range_select_reg <= trace_range_select_next;
            irq_status_reg <= irq_status_next;
            irq_mask_reg <= irq_mask_next;
            wb_ack_reg <= wb_ack_next;
            wb_dat_reg <= wb_dat_next;
            match_reg <= match_next;
            range_reg <= range_next;
            irq_reg <= irq_next;
        end
    end

    assign wb_ack_o = wb_ack_reg;
    assign wb_dat_o = wb_dat_reg;
    assign match_o = match_reg;
    assign trace_in_range_o = range_reg;
    assign irq_o = irq_reg;
endmodule

// File: include/dbm_pkg.sv
// Constants for the debug bus comparator match block
// ============================================================
// What this block does
// - Opcode match flagged at fetch, not execution
// - Later matches skip the original data check
// - Comparators C and D can bound trace range
// - Range-bound comparator gives no address matches
// - Match outputs map to A-D unless ranged
// - Exact address match, masked data match, optional access qualifiers
// - Comparators A and C never compare size
// - Word: lower address byte aligns to high data
// - Word at even address never matches odd
package dbm_pkg;
    // ============================================================
    // Geometry
    localparam int NUM_CMP = 4;
    localparam int WB_AW = 8;
    localparam int WB_DW = 32;
    localparam int CPU_AW = 23;
    localparam int CPU_DW = 16;

    // ============================================================
    // Register byte addresses, comparator k registers at k * CMP_STRIDE + offset
    localparam logic [7:0] CMP_STRIDE = 8'h10;
    localparam logic [7:0] CMP_ADDR_OFS = 8'h00;
    localparam logic [7:0] CMP_DATA_OFS = 8'h04;
    localparam logic [7:0] CMP_MASK_OFS = 8'h08;
    localparam logic [7:0] CMP_CTRL_OFS = 8'h0C;
    localparam logic [7:0] TRACE_CTRL_ADDR = 8'h40;
    localparam logic [7:0] IRQ_STATUS_ADDR = 8'h44;
    localparam logic [7:0] IRQ_MASK_ADDR = 8'h48;

    // ============================================================
    // Comparator control fields
    localparam int CTRL_W = 7;
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_RW_EN = 1;
    localparam int CTRL_RW_VAL = 2;
    localparam int CTRL_SIZE_EN = 3;
    localparam int CTRL_SIZE_VAL = 4;
    localparam int CTRL_OPFETCH = 5;
    localparam int CTRL_DATA_EN = 6;

    // Data / mask register layout: high byte in [15:8], low in [7:0]
    localparam int DATA_HIGH_LSB = 8;
    localparam int DATA_LOW_LSB = 0;

    // ============================================================
    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;
    localparam logic [CPU_DW-1:0] MASK_RESET = 16'hFFFF;
    localparam logic [1:0] RANGE_RESET = 2'h0;

    // Trace range selection encodings
    typedef enum logic [1:0] {
        DBM_RANGE_OFF = 2'b00,
        DBM_RANGE_FROM_C = 2'b01,
        DBM_RANGE_TO_D = 2'b10,
        DBM_RANGE_C_TO_D = 2'b11
    } dbm_range_t;
endpackage

// File: design/dbm_cmp.sv
// One address/data bus comparator with sticky first-hit tracking
`timescale 1ns/1ps
module dbm_cmp #(
    parameter int AW = 23,
    parameter int DW = 16,
    parameter bit HAS_SIZE = 1'b1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Configuration
    input wire logic [AW-1:0] cmp_addr_i,
    input wire logic [DW-1:0] cmp_data_i,
    input wire logic [DW-1:0] cmp_mask_i,
    input wire logic [dbm_pkg::CTRL_W-1:0] cmp_ctrl_i,
    input wire logic rearm_i,
    // Watched bus
    input wire logic bus_valid_i,
    input wire logic [AW-1:0] bus_addr_i,
    input wire logic [DW-1:0] bus_data_i,
    input wire logic bus_read_i,
    input wire logic bus_word_i,
    input wire logic bus_opfetch_i,
    // Result
    output logic hit_o
);
    // ============================================================
    // Compare
    logic addr_eq;
    logic data_ok;
    logic rw_ok;
    logic size_ok;
    logic op_ok;
    logic full_hit;
    logic hit_seen_reg;
    logic hit_seen_next;

    always_comb begin
        // Word at even address never presents the odd one
        addr_eq = bus_addr_i == cmp_addr_i;
        // Bus high lane carries lower address byte
        data_ok = !cmp_ctrl_i[dbm_pkg::CTRL_DATA_EN]
                  || (((bus_data_i ^ cmp_data_i) & cmp_mask_i) == '0);
        rw_ok = !cmp_ctrl_i[dbm_pkg::CTRL_RW_EN]
                || (bus_read_i == cmp_ctrl_i[dbm_pkg::CTRL_RW_VAL]);
        // Size check only exists where the comparator has it
        size_ok = !HAS_SIZE || !cmp_ctrl_i[dbm_pkg::CTRL_SIZE_EN]
                  || (bus_word_i == cmp_ctrl_i[dbm_pkg::CTRL_SIZE_VAL]);
        // Opcode hit taken at fetch time, not at execution
        op_ok = !cmp_ctrl_i[dbm_pkg::CTRL_OPFETCH] || bus_opfetch_i;
        full_hit = cmp_ctrl_i[dbm_pkg::CTRL_ENABLE] && bus_valid_i && addr_eq
                   && data_ok && rw_ok && size_ok && op_ok;
        // After the first hit only the address is checked again
        if (hit_seen_reg) begin
            hit_o = cmp_ctrl_i[dbm_pkg::CTRL_ENABLE] && bus_valid_i && addr_eq;
        end else begin
            hit_o = full_hit;
        end
        hit_seen_next = hit_seen_reg | full_hit;
        if (rearm_i) begin
            hit_seen_next = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hit_seen_reg <= 1'b0;
        end else begin
            hit_seen_reg <= hit_seen_next;
        end
    end
endmodule

// File: tb/dbm_cpu_model.sv
// Processor bus model that drives the watched access bus
`timescale 1ns/1ps
module dbm_cpu_model (
    // Clock
    input wire logic clk_i,
    // Watched bus
    output logic valid_o,
    output logic [dbm_pkg::CPU_AW-1:0] addr_o,
    output logic [dbm_pkg::CPU_DW-1:0] data_o,
    output logic read_o,
    output logic word_o,
    output logic opfetch_o
);
    initial begin
        valid_o = 1'b0;
        addr_o = '0;
        data_o = '0;
        {read_o, word_o, opfetch_o} = 3'h0;
    end

    // One access per call; f is {read, word, opfetch}
    task automatic access(input logic [22:0] a, input logic [15:0] d, input logic [2:0] f);
        @(posedge clk_i);
        valid_o <= 1'b1;
        addr_o <= a;
        data_o <= d;
        {read_o, word_o, opfetch_o} <= f;
        @(posedge clk_i);
        // Released address and data invert, so a stale value never passes for a live one
        valid_o <= 1'b0;
        addr_o <= ~a;
        data_o <= ~d;
    endtask
endmodule

// File: tb/dbm_top_sva.sv
// Port-level assertions for the debug bus comparator block
`timescale 1ns/1ps
module dbm_top_sva (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [dbm_pkg::WB_DW-1:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Watched bus and results
    input wire logic cpu_valid_i,
    input wire logic [dbm_pkg::NUM_CMP-1:0] match_o,
    input wire logic trace_in_range_o,
    input wire logic irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_ack_once;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");
    property p_ack_answer;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("request not acked");
    property p_ack_idle;
        !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
    endproperty
    a_ack_idle: assert property (p_ack_idle) else $error("ack without request");
    property p_dat_quiet;
        !wb_ack_o |-> wb_dat_o == '0;
    endproperty
    a_dat_quiet: assert property (p_dat_quiet) else $error("read data outside ack");
    property p_match_valid;
        !cpu_valid_i |=> match_o == '0;
    endproperty
    a_match_valid: assert property (p_match_valid) else $error("match with no access");
    property p_trace_valid;
        !cpu_valid_i |=> !trace_in_range_o;
    endproperty
    a_trace_valid: assert property (p_trace_valid) else $error("range with no access");
    property p_reset_quiet;
        $fell(rst_i) |-> match_o == '0 && !irq_o && !wb_ack_o;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
    property p_irq_rise;
        $rose(irq_o) |-> match_o != '0 || wb_ack_o || $past(wb_ack_o);
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
    property p_irq_fall;
        $fell(irq_o) |-> wb_ack_o || $past(wb_ack_o);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell without access");
endmodule

bind dbm_top dbm_top_sva dbm_top_sva_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cpu_valid_i(cpu_valid_i),
    .match_o(match_o), .trace_in_range_o(trace_in_range_o), .irq_o(irq_o)
);

// File: tb/dbm_top_bench.sv
// Self-checking bench for the debug bus comparator block
`timescale 1ns/1ps
module dbm_top_bench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_wdat = 32'h00000000;
    logic [31:0] wb_rdat;
    logic wb_ack;
    logic cpu_valid, cpu_read, cpu_word, cpu_opfetch;
    logic [22:0] cpu_addr;
    logic [15:0] cpu_data;
    logic [3:0] match;
    logic trace_hit, irq;
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;

    // ============================================================
    // Design, bus model, clock and watchdog
    dbm_top dbm_top_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
        .wb_ack_o(wb_ack), .cpu_valid_i(cpu_valid), .cpu_addr_i(cpu_addr),
        .cpu_data_i(cpu_data), .cpu_read_i(cpu_read), .cpu_word_i(cpu_word),
        .cpu_opfetch_i(cpu_opfetch), .match_o(match), .trace_in_range_o(trace_hit), .irq_o(irq)
    );
    dbm_cpu_model cpu_model_i (
        .clk_i(clk_i), .valid_o(cpu_valid), .addr_o(cpu_addr), .data_o(cpu_data),
        .read_o(cpu_read), .word_o(cpu_word), .opfetch_o(cpu_opfetch)
    );
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors++;
            end_of_test();
        end
    end

    // ============================================================
    // Access tasks
    task automatic end_of_test();
        if (n_errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_wdat <= d;
        do @(posedge clk_i); while (wb_ack !== 1'b1);
        q = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string what);
        logic [31:0] q;
        wb(1'b0, a, 32'h00000000, q);
        chk(what, e, q);
    endtask
    task automatic cfg(input int k, input logic [31:0] ad, input logic [31:0] d,
                       input logic [31:0] m, input logic [31:0] c);
        logic [7:0] b;
        b = 8'(k * 16);
        wr(b + dbm_pkg::CMP_ADDR_OFS, ad);
        wr(b + dbm_pkg::CMP_DATA_OFS, d);
        wr(b + dbm_pkg::CMP_MASK_OFS, m);
        wr(b + dbm_pkg::CMP_CTRL_OFS, c);
    endtask
    // Flags f are {read, word, opfetch}; e is {in range, match D..A}
    task automatic acc(input logic [22:0] a, input logic [15:0] d, input logic [2:0] f,
                       input logic [4:0] e);
        cpu_model_i.access(a, d, f);
        #1;
        chk("match_trace", {27'h0, e}, {27'h0, trace_hit, match});
    endtask
    task automatic irq_is(input logic e);
        @(posedge clk_i);
        #1;
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask

    // ============================================================
    // Test sequence
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            rd(8'(k * 16 + 8), 32'h0000FFFF, "mask reset");
            rd(8'(k * 16 + 12), 32'h00000000, "ctrl reset");
        end
        rd(8'h40, 32'h00000000, "range reset");
        wr(8'h4C, 32'hFFFFFFFF);
        rd(8'h4C, 32'h00000000, "unmapped");
        cfg(0, 32'h100, 32'h1234, 32'hFFFF, 32'h41);
        acc(23'h000100, 16'h1235, 3'b010, 5'h00);
        acc(23'h000102, 16'h1234, 3'b010, 5'h00);
        acc(23'h000100, 16'h1234, 3'b010, 5'h01);
        acc(23'h000100, 16'hBEEF, 3'b010, 5'h01);
        wr(8'h0C, 32'h41);
        acc(23'h000100, 16'hBEEF, 3'b010, 5'h00);
        // Size compare on: honoured by B, ignored by A
        cfg(0, 32'h100, 32'h1234, 32'hFF00, 32'h59);
        cfg(1, 32'h100, 32'h1234, 32'hFF00, 32'h59);
        acc(23'h000100, 16'h1277, 3'b100, 5'h01);
        acc(23'h000100, 16'h1299, 3'b110, 5'h03);
        cfg(1, 32'h200, 32'h0, 32'h0, 32'h07);
        acc(23'h000200, 16'h0000, 3'b010, 5'h00);
        acc(23'h000200, 16'h0000, 3'b110, 5'h02);
        cfg(2, 32'h300, 32'h1234, 32'h0F0F, 32'h41);
        acc(23'h000300, 16'h1335, 3'b110, 5'h00);
        acc(23'h000300, 16'hA2B4, 3'b110, 5'h04);
        cfg(2, 32'h300, 32'h0056, 32'h00FF, 32'h41);
        cfg(3, 32'h301, 32'h0056, 32'h00FF, 32'h41);
        acc(23'h000300, 16'h9956, 3'b010, 5'h04);
        // Opcode match at 0x500: a plain read misses, only the fetch hits B
        cfg(1, 32'h500, 32'h0, 32'h0, 32'h21);
        acc(23'h000500, 16'h0000, 3'b110, 5'h00);
        acc(23'h000500, 16'h0000, 3'b111, 5'h02);
        cfg(2, 32'h400, 32'h0, 32'h0, 32'h01);
        cfg(3, 32'h4FF, 32'h0, 32'h0, 32'h01);
        acc(23'h000400, 16'h0000, 3'b110, 5'h04);
        acc(23'h000450, 16'h0000, 3'b110, 5'h00);
        wr(8'h40, 32'h3);
        acc(23'h000400, 16'h0000, 3'b110, 5'h18);
        // B already hit at 0x500, so it now matches on address alone
        acc(23'h000500, 16'h0000, 3'b110, 5'h02);
        wr(8'h40, 32'h1);
        acc(23'h0004FF, 16'h0000, 3'b110, 5'h1C);
        acc(23'h0003FF, 16'h0000, 3'b110, 5'h00);
        wr(8'h40, 32'h2);
        acc(23'h000400, 16'h0000, 3'b110, 5'h1C);
        acc(23'h000500, 16'h0000, 3'b110, 5'h02);
        wr(8'h40, 32'h0);
        rd(8'h44, 32'hF, "status");
        rd(8'h44, 32'h0, "status cleared");
        acc(23'h000400, 16'h0000, 3'b110, 5'h04);
        irq_is(1'b0);
        wr(8'h48, 32'h4);
        irq_is(1'b1);
        rd(8'h44, 32'h4, "status");
        irq_is(1'b0);
        // Reset in mid-run returns registers to their idle values
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h48, 32'h0, "irq mask reset");
        rd(8'h2C, 32'h0, "ctrl reset");
        end_of_test();
    end
endmodule
